// [hdl/pme_pkg.sv]
// Purpose: Shared constants and types of the PCI/memory DMA engine.
// Assumes: 32-bit words, four register sets, one shared FIFO.
// Notes: Control word field positions match the software view.
package pme_pkg;
    localparam int PME_SETS       = 4;   // Register sets
    localparam int PME_FIFO_WORDS = 8;   // FIFO depth in words
    localparam int PME_HALF_WORDS = 4;   // Half-full threshold
    localparam int PME_REC_WORDS  = 4;   // Words in one chained record
    localparam int CTL_SIZE_MSB   = 19;  // Byte count field top bit
    localparam int CTL_DRST       = 24;  // Channel reset
    localparam int CTL_MIO        = 25;  // PCI memory (1) or I/O (0)
    localparam int CTL_INC        = 26;  // Increment PCI address
    localparam int CTL_SU         = 27;  // Suspend
    localparam int CTL_GO         = 28;  // Start
    localparam int CTL_DIR        = 29;  // 1: PCI to memory
    localparam int CTL_IE         = 30;  // Completion event enable
    localparam logic [20:0] PME_MAX_BYTES = 21'h100000; // Count of zero
    localparam logic [31:0] PME_CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] PME_ADDR_RST  = 32'h0000_0000;
    localparam logic [1:0]  PME_ERR_MABORT = 2'h1; // Master abort code
    localparam logic [1:0]  PME_ERR_TABORT = 2'h2; // Target abort code
    typedef enum logic [4:0] {
        S_IDLE  = 5'b00001,
        S_GAP   = 5'b00010,
        S_FETCH = 5'b00100,
        S_RUN   = 5'b01000,
        S_DONE  = 5'b10000
    } pme_state_t;
endpackage

// [hdl/pme_fifo.sv]
// Purpose: Flop-based word FIFO shared by both directions.
// Assumes: DEPTH is a power of two; caller never pushes when full.
// Notes: flush_i empties it between transfers.
module pme_fifo import pme_pkg::*; #(
    parameter int WIDTH = 32,
    parameter int DEPTH = PME_FIFO_WORDS,
    parameter int LW    = $clog2(DEPTH) + 1
) (
    input  wire logic             mclk_i,
    input  wire logic             reset_n_i,
    input  wire logic             flush_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] data_o,
    output logic      [LW-1:0]    level_o,
    output logic                  full_o,
    output logic                  empty_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH]; // Word storage
    logic [AW-1:0]    wr_ptr;        // Next write slot
    logic [AW-1:0]    rd_ptr;        // Head slot
    wire              do_push = push_i && !full_o;
    wire              do_pop  = pop_i && !empty_o;

    assign data_o  = store[rd_ptr];
    assign full_o  = (level_o == LW'(DEPTH));
    assign empty_o = (level_o == '0);

    // Storage write
    always_ff @(posedge mclk_i)
    begin
        if (do_push)
            store[wr_ptr] <= data_i;
    end

    // Pointers and fill level
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || flush_i)
        begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            level_o <= '0;
        end
        else
        begin
            if (do_push)
                wr_ptr <= AW'(wr_ptr + 1'b1);
            if (do_pop)
                rd_ptr <= AW'(rd_ptr + 1'b1);
            if (do_push && !do_pop)
                level_o <= LW'(level_o + 1'b1);
            else if (do_pop && !do_push)
                level_o <= LW'(level_o - 1'b1);
        end
    end
endmodule

// [hdl/pme_pick.sv]
// Purpose: Round-robin choice of the next pending register set.
// Assumes: Purely combinational.
// Notes: The set just after last_i has the highest priority.
module pme_pick import pme_pkg::*; (
    input  wire logic [PME_SETS-1:0] pend_i,
    input  wire logic [1:0]          last_i,
    output logic                     found_o,
    output logic      [1:0]          idx_o
);
    // Scan farthest first so the nearest candidate wins
    always_comb
    begin
        logic [1:0] cand;
        cand    = last_i;
        found_o = 1'b0;
        idx_o   = last_i;
        for (int k = PME_SETS; k >= 1; k--)
        begin
            cand = 2'(last_i + 2'(k));
            if (pend_i[cand])
            begin
                found_o = 1'b1;
                idx_o   = cand;
            end
        end
    end
endmodule

// [hdl/pme_dma_engine.sv]
// Purpose: Four-set DMA engine between local memory and PCI through one FIFO.
// Assumes: pci_* inputs come from the PCI clock domain; memory port is on mclk_i.
// Notes: Memory and PCI start addresses share the same byte offset.
module pme_dma_engine import pme_pkg::*; #(
    parameter int FIFO_DEPTH = PME_FIFO_WORDS
) (
    input  wire logic                mclk_i,
    input  wire logic                reset_n_i,
    input  wire logic                cfg_wr_i,
    input  wire logic [1:0]          cfg_set_i,
    input  wire logic [31:0]         cfg_ctrl_i,
    input  wire logic [31:0]         cfg_maddr_i,
    input  wire logic [31:0]         cfg_paddr_i,
    input  wire logic [31:0]         cfg_next_i,
    input  wire logic [PME_SETS-1:0] chain_en_i,
    output logic      [31:0]         set_ctrl_o,
    output logic      [PME_SETS-1:0] busy_o,
    output logic      [20:0]         bytes_left_o,
    input  wire logic                cpu_mem_pend_i,
    input  wire logic                cpu_pci_pend_i,
    output logic                     mem_req_o,
    input  wire logic                mem_gnt_i,
    input  wire logic                mem_ack_i,
    input  wire logic                mem_single_i,
    output logic                     mem_we_o,
    output logic      [31:0]         mem_addr_o,
    output logic      [3:0]          mem_be_o,
    output logic      [31:0]         mem_wdata_o,
    input  wire logic [31:0]         mem_rdata_i,
    input  wire logic                pci_clk_i,
    output logic                     pci_req_o,
    input  wire logic                pci_gnt_i,
    input  wire logic                pci_ack_i,
    input  wire logic                pci_mabort_i,
    input  wire logic                pci_tabort_i,
    input  wire logic [31:0]         pci_rdata_i,
    output logic                     pci_we_o,
    output logic                     pci_mem_space_o,
    output logic      [31:0]         pci_addr_o,
    output logic      [3:0]          pci_be_o,
    output logic      [31:0]         pci_wdata_o,
    output logic                     pci_disc_o,
    output logic      [PME_SETS-1:0] done_o,
    output logic                     dma_err_o,
    output logic      [1:0]          bus_err_o,
    input  wire logic                err_clr_i
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam logic [LW-1:0] HALF = LW'(PME_HALF_WORDS);

    pme_state_t  state, next_state;            // Channel sequencer
    logic [31:0] ctrl  [PME_SETS];             // Control words
    logic [31:0] maddr [PME_SETS];             // Memory start addresses
    logic [31:0] paddr [PME_SETS];             // PCI start addresses
    logic [31:0] nrec  [PME_SETS];             // Next record addresses
    logic [31:0] rec   [PME_REC_WORDS];        // Fetched record
    logic [1:0]  rec_cnt;                      // Record word index
    logic [1:0]  cur;                          // Active set
    logic [19:0] src_left, dst_left, tot;      // Word counters
    logic [31:0] cur_maddr, cur_paddr;         // Current addresses
    logic        dir;                          // Latched direction
    logic [1:0]  off0, endb;                   // First/last byte lanes
    logic        pci_hold, mem_hold;           // Released resources
    logic        pci_on, mem_on;               // Bursts in progress
    logic [36:0] ps1, ps2;                     // PCI-side synchroniser
    logic        pclk_q;                       // Last synced PCI clock
    logic [31:0] fifo_q;                       // FIFO head
    logic [LW-1:0] level;                      // FIFO fill level
    logic        full, empty, found;
    logic [1:0]  pick_idx;
    logic [PME_SETS-1:0] pend;

    // Decodes
    wire        run      = (state == S_RUN);
    wire        active   = (state != S_IDLE);
    wire [31:0] cur_ctrl = ctrl[cur];
    wire        su       = cur_ctrl[CTL_SU];
    wire [20:0] size     = (cur_ctrl[CTL_SIZE_MSB:0] == 20'h0) ? PME_MAX_BYTES
                           : {1'b0, cur_ctrl[CTL_SIZE_MSB:0]};
    wire [1:0]  off      = maddr[cur][1:0];
    wire [21:0] span     = 22'({1'b0, size}) + 22'(off) + 22'd3;
    wire [19:0] nwords   = span[21:2];
    wire [20:0] endpos   = 21'(size + 21'(off) - 21'd1);
    wire        chain_go = chain_en_i[cur] && (nrec[cur] != 32'h0);
    wire        pedge    = ps2[36] && !pclk_q;
    wire        pci_xfer = pedge && pci_req_o && ps2[35] && ps2[34];
    wire        abort_ev = run && pci_req_o && pedge && (ps2[33] || ps2[32]);
    wire        drst_ev  = run && cur_ctrl[CTL_DRST];
    wire        mem_xfer = mem_req_o && mem_gnt_i && mem_ack_i;
    wire        push     = run && (dir ? pci_xfer : mem_xfer);
    wire        pop      = run && (dir ? mem_xfer : pci_xfer);
    wire        src_x    = dir ? push : (run && mem_xfer);
    wire        dst_x    = pop;
    wire        drained  = pop && (level == LW'(1)) && !push;
    wire [LW-1:0] thr    = mem_single_i ? LW'(1) : HALF;
    wire        clr_go   = (state == S_DONE) || abort_ev || drst_ev;
    wire        ld_rec   = (state == S_FETCH) && mem_xfer && (rec_cnt == 2'(PME_REC_WORDS - 1));
    wire [3:0]  be_first = (dst_left == tot) ? 4'(4'hf << off0) : 4'hf;
    wire [3:0]  be_dst   = (dst_left == 20'h1) ? (be_first & 4'(4'hf >> (2'd3 - endb))) : be_first;

    // Port drives
    assign mem_req_o = (state == S_FETCH) || (run && (dir
                       ? (!empty && (mem_on || level >= HALF || src_left == 20'h0))
                       : (src_left != 20'h0 && !mem_hold && !full && !su)));
    assign pci_req_o = run && (dir
                       ? (src_left != 20'h0 && !pci_hold && !full && !su)
                       : (pci_on && !empty && !su));
    assign mem_we_o        = run && dir;
    assign mem_addr_o      = cur_maddr;
    assign mem_be_o        = dir ? be_dst : 4'hf;
    assign mem_wdata_o     = fifo_q;
    assign pci_addr_o      = cur_paddr;
    assign pci_be_o        = dir ? 4'hf : be_dst;
    assign pci_wdata_o     = fifo_q;
    assign pci_we_o        = !dir;
    assign pci_mem_space_o = cur_ctrl[CTL_MIO];
    assign busy_o          = active ? 4'(4'h1 << cur) : 4'h0;
    assign set_ctrl_o      = {busy_o[cfg_set_i], ctrl[cfg_set_i][30:0]};

    // Pending sets: start bit set and not being reset
    for (genvar g = 0; g < PME_SETS; g++)
    begin : g_set
        wire is_cur = active && (cur == 2'(g));
        assign pend[g] = ctrl[g][CTL_GO] && !ctrl[g][CTL_DRST];
        // Register set write, record load and hardware clears
        always_ff @(posedge mclk_i)
        begin
            if (!reset_n_i)
            begin
                ctrl[g]  <= PME_CTRL_RST;
                maddr[g] <= PME_ADDR_RST;
                paddr[g] <= PME_ADDR_RST;
                nrec[g]  <= PME_ADDR_RST;
            end
            else
            begin
                if (cfg_wr_i && cfg_set_i == 2'(g))
                begin
                    if (is_cur)
                    begin
                        // Running set: only suspend and reset apply
                        ctrl[g][CTL_SU]   <= cfg_ctrl_i[CTL_SU];
                        ctrl[g][CTL_DRST] <= cfg_ctrl_i[CTL_DRST];
                    end
                    else
                    begin
                        ctrl[g]  <= cfg_ctrl_i;
                        maddr[g] <= cfg_maddr_i;
                        paddr[g] <= cfg_paddr_i;
                        nrec[g]  <= cfg_next_i;
                    end
                end
                if (!is_cur && ctrl[g][CTL_DRST])
                begin
                    ctrl[g][CTL_GO]   <= 1'b0;
                    ctrl[g][CTL_DRST] <= 1'b0;
                end
                if (clr_go && is_cur)
                begin
                    ctrl[g][CTL_GO]   <= 1'b0;
                    ctrl[g][CTL_DRST] <= 1'b0;
                end
                if (ld_rec && is_cur)
                begin
                    ctrl[g]          <= rec[0];
                    ctrl[g][CTL_GO]  <= 1'b1;
                    maddr[g]         <= rec[1];
                    paddr[g]         <= rec[2];
                    nrec[g]          <= mem_rdata_i;
                end
            end
        end
    end

    pme_pick u_pick (
        .pend_i  (pend),
        .last_i  (cur),
        .found_o (found),
        .idx_o   (pick_idx)
    );

    pme_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk_i    (mclk_i),
        .reset_n_i (reset_n_i),
        .flush_i   (state == S_GAP),
        .push_i    (push),
        .data_i    (dir ? ps2[31:0] : mem_rdata_i),
        .pop_i     (pop),
        .data_o    (fifo_q),
        .level_o   (level),
        .full_o    (full),
        .empty_o   ()
    );
    assign empty = (level == '0);

    // Two-flop crossing of all PCI-side inputs
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            ps1    <= '0;
            ps2    <= '0;
            pclk_q <= 1'b0;
        end
        else
        begin
            ps1    <= {pci_clk_i, pci_gnt_i, pci_ack_i, pci_mabort_i, pci_tabort_i, pci_rdata_i};
            ps2    <= ps1;
            pclk_q <= ps2[36];
        end
    end

    // Next state
    always_comb
    begin
        next_state = state;
        case (state)
            S_IDLE:  if (found) next_state = S_GAP;
            S_GAP:   if (!cpu_mem_pend_i && !cpu_pci_pend_i) next_state = S_RUN;
            S_FETCH: if (ld_rec) next_state = S_GAP;
            S_RUN:
                if (abort_ev || drst_ev)
                    next_state = S_IDLE;
                else if (dst_left == 20'h0)
                    next_state = S_DONE;
            S_DONE:  next_state = chain_go ? S_FETCH : S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // State, active set and record capture
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            state   <= S_IDLE;
            cur     <= 2'h0;
            rec_cnt <= 2'h0;
        end
        else
        begin
            state <= next_state;
            if (state == S_IDLE && found)
                cur <= pick_idx;
            if (state == S_DONE)
                rec_cnt <= 2'h0;
            else if (state == S_FETCH && mem_xfer)
            begin
                rec[rec_cnt] <= mem_rdata_i;
                rec_cnt      <= 2'(rec_cnt + 2'h1);
            end
        end
    end

    // Word, byte and address counters
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            src_left     <= 20'h0;
            dst_left     <= 20'h0;
            tot          <= 20'h0;
            bytes_left_o <= 21'h0;
            cur_maddr    <= PME_ADDR_RST;
            cur_paddr    <= PME_ADDR_RST;
            dir          <= 1'b0;
            off0         <= 2'h0;
            endb         <= 2'h0;
        end
        else if (state == S_GAP)
        begin
            src_left     <= nwords;
            dst_left     <= nwords;
            tot          <= nwords;
            bytes_left_o <= size;
            cur_maddr    <= {maddr[cur][31:2], 2'h0};
            cur_paddr    <= {paddr[cur][31:2], 2'h0};
            dir          <= cur_ctrl[CTL_DIR];
            off0         <= off;
            endb         <= endpos[1:0];
        end
        else if (state == S_DONE)
            cur_maddr <= {nrec[cur][31:4], 4'h0};
        else
        begin
            if (mem_xfer)
                cur_maddr <= 32'(cur_maddr + 32'h4);
            if (run && pci_xfer && cur_ctrl[CTL_INC])
                cur_paddr <= 32'(cur_paddr + 32'h4);
            if (src_x)
                src_left <= 20'(src_left - 20'h1);
            if (dst_x)
            begin
                dst_left     <= 20'(dst_left - 20'h1);
                bytes_left_o <= (bytes_left_o > 21'h4) ? 21'(bytes_left_o - 21'h4) : 21'h0;
            end
        end
    end

    // Bus holds and burst flags
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i || !run)
        begin
            pci_hold   <= 1'b0;
            mem_hold   <= 1'b0;
            pci_on     <= 1'b0;
            mem_on     <= 1'b0;
            pci_disc_o <= 1'b0;
        end
        else
        begin
            if (full)
                {pci_hold, mem_hold} <= {dir, !dir};
            else if (level <= HALF)
                {pci_hold, mem_hold} <= 2'b00;
            mem_on <= dir && mem_req_o && !drained;
            if (!dir && pci_on && drained)
                pci_on <= 1'b0;
            else if (!dir && (level >= thr || (src_left == 20'h0 && !empty)))
                pci_on <= 1'b1;
            pci_disc_o <= !dir && pci_on && drained && (dst_left != 20'h1);
        end
    end

    // Completion and error events
    always_ff @(posedge mclk_i)
    begin
        if (!reset_n_i)
        begin
            done_o    <= 4'h0;
            dma_err_o <= 1'b0;
            bus_err_o <= 2'h0;
        end
        else
        begin
            done_o    <= (state == S_DONE && !chain_go && cur_ctrl[CTL_IE])
                         ? 4'(4'h1 << cur) : 4'h0;
            dma_err_o <= abort_ev;
            if (abort_ev)
                bus_err_o <= bus_err_o | (ps2[33] ? PME_ERR_MABORT : 2'h0)
                             | (ps2[32] ? PME_ERR_TABORT : 2'h0);
            else if (err_clr_i)
                bus_err_o <= 2'h0;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    property p_fifo_bound;
        level <= LW'(FIFO_DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");
    property p_rd_mem_late;
        (run && dir && $rose(mem_req_o)) |-> (level >= HALF || src_left == 20'h0);
    endproperty
    a_rd_mem_late: assert property (p_rd_mem_late) else $error("memory asked too early");
    property p_rd_hold;
        (run && dir && pci_hold && level > HALF) |=> (pci_hold && !pci_req_o);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("pci not released");
    property p_wr_hold;
        (run && !dir && full) |-> !mem_req_o ##1 (mem_hold || !run);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("memory not released");
    property p_wr_pci_late;
        (run && !dir && $rose(pci_on)) |-> ($past(level) >= thr || src_left == 20'h0);
    endproperty
    a_wr_pci_late: assert property (p_wr_pci_late) else $error("pci asked too early");
    property p_src_stop;
        (run && src_left == 20'h0) |-> !src_x;
    endproperty
    a_src_stop: assert property (p_src_stop) else $error("filled past end");
    property p_gap_wait;
        (state == S_GAP && (cpu_mem_pend_i || cpu_pci_pend_i)) |=> state == S_GAP;
    endproperty
    a_gap_wait: assert property (p_gap_wait) else $error("started over cpu access");
    property p_abort;
        abort_ev |=> (state == S_IDLE && dma_err_o && bus_err_o != 2'h0);
    endproperty
    a_abort: assert property (p_abort) else $error("abort not handled");
    property p_chain_quiet;
        (state == S_DONE && chain_go) |=> (done_o == 4'h0 && state == S_FETCH);
    endproperty
    a_chain_quiet: assert property (p_chain_quiet) else $error("chain event early");
    property p_go_clear;
        (state == S_DONE && !chain_go) |=> !ctrl[$past(cur)][CTL_GO];
    endproperty
    a_go_clear: assert property (p_go_clear) else $error("start bit kept");

    c_chain: cover property (state == S_DONE && chain_go);
    c_abort: cover property (abort_ev);
    c_disc:  cover property (pci_disc_o);
endmodule

// [tb/pme_far_model.sv]
// Purpose: Far side of the engine: local memory and a PCI target.
// Assumes: Both answer at once; link clock runs free at 320 ns.
// Notes: Memory data follow the address, PCI data the word count.
module pme_far_model (
    input  wire logic        mclk_i,
    input  wire logic        mem_req_i,
    input  wire logic [31:0] mem_addr_i,
    output logic             mem_gnt_o,
    output logic      [31:0] mem_rdata_o,
    output logic             pci_clk_o,
    input  wire logic        pci_req_i,
    output logic             pci_gnt_o,
    output logic      [31:0] pci_rdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] pcnt = 32'h0;  // PCI words served
    initial pci_clk_o = 1'b0;
    always #160 pci_clk_o = ~pci_clk_o;
    // Grant as soon as asked; idle data inverted so nothing stale shows
    assign mem_gnt_o   = mem_req_i;
    assign mem_rdata_o = mem_req_i ? (mem_addr_i ^ 32'ha5a5_0000) : ~(mem_addr_i ^ 32'ha5a5_0000);
    assign pci_gnt_o   = pci_req_i;
    // Count words at the link edge, move data half a period later
    always @(posedge pci_clk_o) if (pci_req_i) pcnt <= pcnt + 32'h1;
    always @(negedge pci_clk_o) pci_rdata_o <= 32'hc0de_0000 + pcnt;
endmodule

// [tb/tb_pme_dma_engine.sv]
// Purpose: Bench for the DMA engine: write, read, abort then pending set.
// Assumes: Far side answers promptly.
// Notes: Chaining is left idle.
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("mismatch %0t got %h exp %h", $time, a, b); end end
module tb_pme_dma_engine;
    timeunit 1ns;
    timeprecision 1ns;
    import pme_pkg::*;
    logic        mclk_i = 0, reset_n_i = 0, cfg_wr_i = 0, pend = 0, tab = 0, clr = 0, on = 0;
    logic [1:0]  cfg_set_i = 0;
    logic [31:0] cfg_ctrl_i = 0, cfg_maddr_i = 0, cfg_paddr_i = 0, mbase = 0, pbase = 0, set_ctrl_o, mem_addr_o;
    logic [31:0] mem_wdata_o, mem_rdata_i, pci_rdata_i, pci_wdata_o, pci_addr_o;
    logic [20:0] bytes_left_o;
    logic [3:0]  busy_o, done_o, mem_be_o;
    logic [1:0]  bus_err_o;
    logic        mem_req_o, mem_gnt_i, mem_we_o, pci_clk_i, pci_req_o, pci_gnt_i, pci_we_o, dma_err_o;
    int          err_total = 0, checks = 0, mr, mw, pw;
    always #20 mclk_i = ~mclk_i;
    pme_dma_engine u_pme_dma_engine (.mclk_i, .reset_n_i, .cfg_wr_i, .cfg_set_i, .cfg_ctrl_i, .cfg_maddr_i,
        .cfg_paddr_i, .cfg_next_i(32'h0), .chain_en_i(4'h0), .set_ctrl_o, .busy_o, .bytes_left_o,
        .cpu_mem_pend_i(pend), .cpu_pci_pend_i(pend), .mem_req_o, .mem_gnt_i, .mem_ack_i(mem_gnt_i),
        .mem_single_i(1'b0), .mem_we_o, .mem_addr_o, .mem_be_o, .mem_wdata_o, .mem_rdata_i, .pci_clk_i,
        .pci_req_o, .pci_gnt_i, .pci_ack_i(pci_gnt_i), .pci_mabort_i(1'b0), .pci_tabort_i(tab), .pci_rdata_i,
        .pci_we_o, .pci_mem_space_o(), .pci_addr_o, .pci_be_o(), .pci_wdata_o, .pci_disc_o(), .done_o,
        .dma_err_o, .bus_err_o, .err_clr_i(clr));
    pme_far_model u_pme_far_model (.mclk_i, .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_gnt_o(mem_gnt_i),
        .mem_rdata_o(mem_rdata_i), .pci_clk_o(pci_clk_i), .pci_req_i(pci_req_o), .pci_gnt_o(pci_gnt_i),
        .pci_rdata_o(pci_rdata_i));
    // Memory side monitor: order, data, addresses, FIFO bound
    always @(posedge mclk_i)
    begin
        if (on && mem_req_o && mem_we_o) `CHK(mem_wdata_o, 32'hc0de_0000 + pbase + 32'(mw))
        if (on && mem_req_o && mem_we_o) `CHK(mem_be_o, 4'hf)
        if (on && mem_req_o) `CHK(mem_addr_o, mbase + 32'(4 * (mr + mw)))
        if (on && pci_req_o && pci_we_o) `CHK(mr >= 4, 1'b1)
        if (on) `CHK(mr - pw <= 8, 1'b1)
        if (mem_req_o && mem_we_o) mw++;
        if (mem_req_o && !mem_we_o) mr++;
    end
    // PCI side monitor: written data follow memory order
    always @(posedge pci_clk_i) if (on && pci_req_o && pci_we_o)
    begin
        `CHK(pci_wdata_o, (mbase + 32'(4 * pw)) ^ 32'ha5a5_0000)
        `CHK(pci_addr_o, (mbase | 32'h8000_0000) + 32'(4 * pw))
        pw++;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic prog(input logic [1:0] s, input logic [31:0] c, input logic [31:0] ma);
        @(posedge mclk_i);
        {cfg_wr_i, cfg_set_i, cfg_ctrl_i, cfg_maddr_i, cfg_paddr_i} <= {1'b1, s, c, ma, ma | 32'h8000_0000};
        @(posedge mclk_i);
        cfg_wr_i <= 1'b0;
        {mr, mw, pw} = {32'd0, 32'd0, 32'd0};
    endtask
    // Bounded wait for done of a set, or the error pulse when s is 4
    task automatic wait_for(input int s);
        int n;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            #1 n++;
        end while (!(s < 4 ? done_o[s[1:0]] === 1'b1 : dma_err_o === 1'b1) && n < 3000);
        if (n >= 3000) err_total++;
        if (n >= 3000) results();
    endtask
    task automatic t_write;
        {on, mbase} = {1'b1, 32'h1000};
        pend <= 1'b1;
        prog(0, 32'h5600_0020, mbase);
        repeat (6) @(posedge mclk_i);
        `CHK(mem_req_o, 1'b0)
        `CHK(busy_o, 4'h1)
        pend <= 0;
        wait_for(0);
        `CHK(pw, 8)
        `CHK(bytes_left_o, 21'h0)
        repeat (2) @(posedge mclk_i);
        #1 `CHK(busy_o, 4'h0)
        `CHK(set_ctrl_o[CTL_GO], 1'b0)
    endtask
    task automatic t_read;
        mbase = 32'h2000;
        prog(1, 32'h7200_0010, mbase);
        // Far side word counter keeps running across transfers
        pbase = u_pme_far_model.pcnt;
        wait_for(1);
        `CHK(mw, 4)
        `CHK(mr, 0)
    endtask
    task automatic t_abort;
        {on, tab} <= 2'b01;
        prog(2, 32'h5600_0020, 32'h3000);
        prog(3, 32'h5600_0008, 32'h4000);
        wait_for(4);
        `CHK(bus_err_o, 2'h2)
        @(posedge mclk_i) tab <= 0;
        wait_for(3);
        `CHK(done_o[3], 1'b1)
        @(posedge mclk_i) clr <= 1;
        @(posedge mclk_i) clr <= 0;
        @(posedge mclk_i) #1 `CHK(bus_err_o, 2'h0)
    endtask
    initial
    begin
        repeat (8) @(posedge mclk_i);
        reset_n_i <= 1;
        t_write();
        t_read();
        t_abort();
        results();
    end
endmodule
